// ===== hw/odt_pkg.sv
/*
  Constants for the on-chip debug trace register block: byte offsets, field
  positions, trigger mode codes and reset values.
  Assumes an 8-bit register port with a 4-bit byte index and one system clock.
*/
package odt_pkg;
  // ==========================================================================
  // Register byte offsets
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_CA_HI = 4'h0;
  localparam logic [3:0] OFS_CA_LO = 4'h1;
  localparam logic [3:0] OFS_CB_HI = 4'h2;
  localparam logic [3:0] OFS_CB_LO = 4'h3;
  localparam logic [3:0] OFS_FIFO_HI = 4'h4;
  localparam logic [3:0] OFS_FIFO_LO = 4'h5;
  localparam logic [3:0] OFS_CTL = 4'h6;
  localparam logic [3:0] OFS_TRG = 4'h7;
  localparam logic [3:0] OFS_STS = 4'h8;
  localparam logic [3:0] OFS_FRC = 4'h9;
  // ==========================================================================
  // Control byte fields
  localparam int CTL_EN = 7;
  localparam int CTL_ARM = 6;
  localparam int CTL_TAG = 5;
  localparam int CTL_BRK = 4;
  localparam int CTL_DIR_A = 3;
  localparam int CTL_DIR_A_EN = 2;
  localparam int CTL_DIR_B = 1;
  localparam int CTL_DIR_B_EN = 0;
  // ==========================================================================
  // Trigger byte, status byte and force-reset fields
  localparam int TRG_SEL = 7;
  localparam int TRG_BEGIN = 6;
  localparam logic [7:0] TRG_WR_MASK = 8'hCF;
  localparam int STS_AF = 7;
  localparam int STS_BF = 6;
  localparam int STS_RUN = 5;
  localparam int FRC_BIT = 0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // ==========================================================================
  // Trigger mode codes
  localparam logic [3:0] MODE_A_ONLY = 4'h0;
  localparam logic [3:0] MODE_A_OR_B = 4'h1;
  localparam logic [3:0] MODE_A_THEN_B = 4'h2;
  localparam logic [3:0] MODE_EVT_B = 4'h3;
  localparam logic [3:0] MODE_A_THEN_EVT = 4'h4;
  localparam logic [3:0] MODE_A_AND_BD = 4'h5;
  localparam logic [3:0] MODE_A_NOT_BD = 4'h6;
  localparam logic [3:0] MODE_INSIDE = 4'h7;
  localparam logic [3:0] MODE_OUTSIDE = 4'h8;
  // ==========================================================================
  // Sizes
  localparam int FIFO_DEPTH = 8;
  localparam int WORD_W = 16;
endpackage : odt_pkg

// ===== hw/odt_skid2.sv
/*
  Two-entry buffer with valid and ready on both sides; all outputs registered.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module odt_skid2 #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [1:0] cnt_after;
  logic [WIDTH-1:0] ent1_r;
  logic push;
  logic pop;

  // Handshakes and occupancy
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign cnt_after = cnt_r - {1'b0, pop};
  assign cnt_nxt = cnt_after + {1'b0, push};

  // Occupancy and registered flags; ready drops only when both entries hold
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 2'h0;
      out_valid <= 1'b0;
      in_ready <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      out_valid <= (cnt_nxt != 2'h0);
      in_ready <= (cnt_nxt != 2'h2);
    end
  end

  // Entry storage; head moves up on pop, new word lands behind survivors
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_data <= '0;
      ent1_r <= '0;
    end else begin
      if (pop) begin
        out_data <= ent1_r;
      end
      if (push) begin
        if (cnt_after == 2'h0) begin
          out_data <= in_data;
        end else begin
          ent1_r <= in_data;
        end
      end
    end
  end
endmodule : odt_skid2

// ===== hw/odt_debug_regs.sv
/*
  Debug unit register file: comparators A and B, trace buffer ports, control,
  trigger, status and force-reset bytes, plus the capture and break logic.
  Assumes CPU bus monitor signals synchronous to sys_clk, and that the
  register port marks background-debug accesses with bus_bdc.
*/
`timescale 1ns/1ps
module odt_debug_regs #(
  parameter int DEPTH = odt_pkg::FIFO_DEPTH,
  parameter int CNT_W = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port
  input wire logic bus_req,
  input wire logic bus_wr,
  input wire logic bus_bdc,
  input wire logic [odt_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic bus_rdy,
  // Read answers
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  input wire logic rsp_ready,
  // CPU bus monitor
  input wire logic cpu_valid,
  input wire logic cpu_rd,
  input wire logic cpu_opfetch,
  input wire logic cpu_cof,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_data,
  input wire logic cpu_secure,
  // Requests to the core
  output logic mcu_reset_req,
  output logic brk_req,
  output logic brk_tag
);
  // ==========================================================================
  // Declarations
  logic [7:0] ca_hi_r, ca_lo_r, cb_hi_r, cb_lo_r;
  logic [7:0] ctl_r;
  logic [7:0] trg_r;
  logic arm_r, af_r, bf_r, seq_r, started_r;
  logic [CNT_W-1:0] cnt_r;
  logic [15:0] last_op_r;
  logic [odt_pkg::WORD_W-1:0] fifo_r [0:DEPTH-1];
  logic bus_take, rd_take, wr_take, wr_user;
  logic [7:0] rd_byte;
  logic [15:0] cmp_a, cmp_b;
  logic dir_a_ok, dir_b_ok, match_a, match_b, trig;
  logic evt_mode, begin_like, capture, cap_full, end_run;
  logic arm_start, arm_stop;
  logic [odt_pkg::WORD_W-1:0] cap_word;
  logic fl_read;
  logic [3:0] mode;

  // ==========================================================================
  // Register port decode
  assign bus_take = bus_req & bus_rdy;
  assign rd_take = bus_take & ~bus_wr;
  assign wr_take = bus_take & bus_wr;
  assign wr_user = wr_take & ~bus_bdc;
  assign fl_read = rd_take & (bus_addr == odt_pkg::OFS_FIFO_LO);
  assign mode = trg_r[3:0];

  // Read multiplexer; trace ports are read-only, unmapped indexes read zero
  always_comb begin
    rd_byte = odt_pkg::BYTE_ZERO;
    case (bus_addr)
      odt_pkg::OFS_CA_HI: rd_byte = ca_hi_r;
      odt_pkg::OFS_CA_LO: rd_byte = ca_lo_r;
      odt_pkg::OFS_CB_HI: rd_byte = cb_hi_r;
      odt_pkg::OFS_CB_LO: rd_byte = cb_lo_r;
      odt_pkg::OFS_FIFO_HI: rd_byte = evt_mode ? odt_pkg::BYTE_ZERO : fifo_r[0][15:8];
      odt_pkg::OFS_FIFO_LO: rd_byte = fifo_r[0][7:0];
      odt_pkg::OFS_CTL: rd_byte = ctl_r;
      odt_pkg::OFS_TRG: rd_byte = trg_r;
      odt_pkg::OFS_STS: rd_byte = {af_r, bf_r, arm_r, 1'b0, cnt_r[3:0]};
      odt_pkg::OFS_FRC: rd_byte = odt_pkg::BYTE_ZERO;
      default: rd_byte = odt_pkg::BYTE_ZERO;
    endcase
  end

  // Answer buffer; a stalled reader holds off further register requests
  odt_skid2 #(.WIDTH(8)) u_rsp_buf (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_valid(rd_take),
    .in_data(rd_byte),
    .in_ready(bus_rdy),
    .out_valid(rsp_valid),
    .out_data(rsp_data),
    .out_ready(rsp_ready)
  );

  // ==========================================================================
  // Comparator bytes, locked while armed so a run sees stable targets
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ca_hi_r <= odt_pkg::BYTE_ZERO;
      ca_lo_r <= odt_pkg::BYTE_ZERO;
      cb_hi_r <= odt_pkg::BYTE_ZERO;
      cb_lo_r <= odt_pkg::BYTE_ZERO;
    end else if (wr_take && !arm_r) begin
      case (bus_addr)
        odt_pkg::OFS_CA_HI: ca_hi_r <= bus_wdata;
        odt_pkg::OFS_CA_LO: ca_lo_r <= bus_wdata;
        odt_pkg::OFS_CB_HI: cb_hi_r <= bus_wdata;
        odt_pkg::OFS_CB_LO: cb_lo_r <= bus_wdata;
        default: ;
      endcase
    end
  end

  // Trigger byte; bits 5 and 4 always read zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      trg_r <= odt_pkg::BYTE_ZERO;
    end else if (wr_take && !arm_r && bus_addr == odt_pkg::OFS_TRG) begin
      trg_r <= bus_wdata & odt_pkg::TRG_WR_MASK;
    end
  end

  // ==========================================================================
  // Control byte and arm; a write that arms wins over a run end in that cycle
  assign arm_start = wr_take && bus_addr == odt_pkg::OFS_CTL && bus_wdata[odt_pkg::CTL_ARM]
                     && bus_wdata[odt_pkg::CTL_EN] && !cpu_secure;
  assign arm_stop = wr_take && bus_addr == odt_pkg::OFS_CTL && !arm_start;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_r <= odt_pkg::BYTE_ZERO;
    end else if (wr_take && bus_addr == odt_pkg::OFS_CTL) begin
      ctl_r <= bus_wdata;
      ctl_r[odt_pkg::CTL_EN] <= bus_wdata[odt_pkg::CTL_EN] & ~cpu_secure;
      ctl_r[odt_pkg::CTL_ARM] <= arm_start;
    end else if (end_run) begin
      ctl_r[odt_pkg::CTL_ARM] <= 1'b0;
    end
  end

  // Armed flag mirrors the arm bit
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      arm_r <= 1'b0;
    end else if (arm_start) begin
      arm_r <= 1'b1;
    end else if (arm_stop || end_run) begin
      arm_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Comparators and trigger evaluation
  assign cmp_a = {ca_hi_r, ca_lo_r};
  assign cmp_b = {cb_hi_r, cb_lo_r};
  assign dir_a_ok = !ctl_r[odt_pkg::CTL_DIR_A_EN] || (cpu_rd == ctl_r[odt_pkg::CTL_DIR_A]);
  assign dir_b_ok = !ctl_r[odt_pkg::CTL_DIR_B_EN] || (cpu_rd == ctl_r[odt_pkg::CTL_DIR_B]);
  assign match_a = cpu_valid && cpu_addr == cmp_a && dir_a_ok;
  assign match_b = cpu_valid && cpu_addr == cmp_b && dir_b_ok;
  assign evt_mode = (mode == odt_pkg::MODE_EVT_B) || (mode == odt_pkg::MODE_A_THEN_EVT);
  assign begin_like = evt_mode || trg_r[odt_pkg::TRG_BEGIN];

  // Trigger per mode; unused codes never fire
  always_comb begin
    trig = 1'b0;
    case (mode)
      odt_pkg::MODE_A_ONLY: trig = match_a;
      odt_pkg::MODE_A_OR_B: trig = match_a | match_b;
      odt_pkg::MODE_A_THEN_B: trig = seq_r & match_b;
      odt_pkg::MODE_EVT_B: trig = match_b;
      odt_pkg::MODE_A_THEN_EVT: trig = seq_r & match_b;
      odt_pkg::MODE_A_AND_BD: trig = match_a && cpu_data == cb_lo_r;
      odt_pkg::MODE_A_NOT_BD: trig = match_a && cpu_data != cb_lo_r;
      odt_pkg::MODE_INSIDE: trig = cpu_valid && cpu_addr >= cmp_a && cpu_addr <= cmp_b;
      odt_pkg::MODE_OUTSIDE: trig = cpu_valid && (cpu_addr < cmp_a || cpu_addr > cmp_b);
      default: trig = 1'b0;
    endcase
  end

  // Capture: event words on trigger, flow addresses after begin or before end
  always_comb begin
    capture = 1'b0;
    if (ctl_r[odt_pkg::CTL_EN] && arm_r) begin
      if (evt_mode) begin
        capture = trig;
      end else if (begin_like) begin
        capture = cpu_cof && (started_r || trig);
      end else begin
        capture = cpu_cof;
      end
    end
  end
  assign cap_word = evt_mode ? {odt_pkg::BYTE_ZERO, cpu_data} : cpu_addr;
  assign cap_full = capture && (cnt_r == CNT_W'(DEPTH - 1));
  assign end_run = arm_r && !arm_start && (begin_like ? cap_full : trig);

  // Sequence, begin and match flags, cleared at each arm
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_r <= 1'b0;
      started_r <= 1'b0;
      af_r <= 1'b0;
      bf_r <= 1'b0;
    end else if (arm_start) begin
      seq_r <= 1'b0;
      started_r <= 1'b0;
      af_r <= 1'b0;
      bf_r <= 1'b0;
    end else if (arm_r) begin
      seq_r <= seq_r | match_a;
      started_r <= started_r | trig;
      af_r <= af_r | match_a;
      bf_r <= bf_r | match_b;
    end
  end

  // Valid-word count, held after the run and not touched by reads
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (arm_start) begin
      cnt_r <= '0;
    end else if (capture && cnt_r != CNT_W'(DEPTH)) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // Latest opcode fetch address for profiling
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_op_r <= '0;
    end else if (cpu_valid && cpu_opfetch) begin
      last_op_r <= cpu_addr;
    end
  end

  // ==========================================================================
  // Trace buffer: shifts toward the head; tail takes captures or profile words.
  // Lower-port reads while armed are dropped to keep capture order intact.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        fifo_r[i] <= '0;
      end
    end else if (capture || (fl_read && !arm_r)) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        fifo_r[i] <= fifo_r[i+1];
      end
      fifo_r[DEPTH-1] <= capture ? cap_word : last_op_r;
    end
  end

  // ==========================================================================
  // Requests to the core
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mcu_reset_req <= 1'b0;
    end else begin
      mcu_reset_req <= wr_take && bus_bdc && bus_addr == odt_pkg::OFS_FRC
                       && bus_wdata[odt_pkg::FRC_BIT];
    end
  end

  // Break at run end; type bit only matters while breaks are enabled
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      brk_req <= 1'b0;
      brk_tag <= 1'b0;
    end else begin
      brk_req <= end_run && ctl_r[odt_pkg::CTL_BRK];
      brk_tag <= end_run && ctl_r[odt_pkg::CTL_BRK] && ctl_r[odt_pkg::CTL_TAG];
    end
  end

  // ==========================================================================
  // Assertions
  // All sample on sys_clk and sleep while rst_b is low
  frc_reads_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (rd_take && bus_addr == odt_pkg::OFS_FRC && !rsp_valid) |=> (rsp_valid && rsp_data == odt_pkg::BYTE_ZERO))
    else $error("force-reset byte read non-zero");

  user_frc_ignored_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_user && bus_addr == odt_pkg::OFS_FRC) |=> !mcu_reset_req)
    else $error("user write caused reset");

  bdc_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_take && bus_bdc && bus_addr == odt_pkg::OFS_FRC && bus_wdata[odt_pkg::FRC_BIT])
    |=> mcu_reset_req ##1 !mcu_reset_req)
    else $error("background reset not one pulse");

  cmp_locked_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_take && arm_r && bus_addr == odt_pkg::OFS_CA_HI) |=> $stable(ca_hi_r))
    else $error("comparator written while armed");

  cmp_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_take && !arm_r && bus_addr == odt_pkg::OFS_CB_LO) |=> cb_lo_r == $past(bus_wdata))
    else $error("comparator write lost");

  evt_hi_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (rd_take && evt_mode && bus_addr == odt_pkg::OFS_FIFO_HI && !rsp_valid) |=> rsp_data == odt_pkg::BYTE_ZERO)
    else $error("upper port non-zero in event mode");

  secure_enable_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_take && cpu_secure && bus_addr == odt_pkg::OFS_CTL) |=> !ctl_r[odt_pkg::CTL_EN] && !arm_r)
    else $error("enable set while secured");

  arm_sets_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    arm_start |=> arm_r && ctl_r[odt_pkg::CTL_ARM] && cnt_r == '0)
    else $error("arm write did not arm");

  armed_read_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (fl_read && arm_r && !capture) |=> $stable(fifo_r[0]))
    else $error("armed read advanced buffer");

  profile_store_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (fl_read && !arm_r) |=> fifo_r[DEPTH-1] == $past(last_op_r))
    else $error("profile word not stored");

  run_end_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    end_run |=> !arm_r && (brk_req == $past(ctl_r[odt_pkg::CTL_BRK])))
    else $error("run end mishandled");

  count_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!arm_r && !arm_start) |=> $stable(cnt_r))
    else $error("count changed while idle");

  brk_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    brk_req |=> !brk_req)
    else $error("break held too long");

  brk_type_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    brk_req |-> brk_tag == $past(ctl_r[odt_pkg::CTL_TAG]))
    else $error("break type wrong");

  run_end_arm_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    end_run |=> !ctl_r[odt_pkg::CTL_ARM])
    else $error("arm bit kept after run end");

  cnt_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cnt_r <= CNT_W'(DEPTH))
    else $error("count beyond depth");

  // Scenarios worth reaching
  run_done_c: cover property (@(posedge sys_clk) disable iff (!rst_b) arm_start ##[1:50] end_run);
  profile_read_c: cover property (@(posedge sys_clk) disable iff (!rst_b) fl_read && !arm_r);
  bdc_reset_c: cover property (@(posedge sys_clk) disable iff (!rst_b) mcu_reset_req);
  begin_brk_c: cover property (@(posedge sys_clk) disable iff (!rst_b) brk_req && begin_like && !evt_mode);
  evt_fill_c: cover property (@(posedge sys_clk) disable iff (!rst_b) cap_full && evt_mode);
endmodule : odt_debug_regs

// ===== dv/odt_host_model.sv
/*
  Debug host stand-in on the answer side of the register port: takes read
  answers, can stall them, and reports the last byte and a running count.
  Assumes the bench drives stall just after the rising edge of sys_clk.
*/
`timescale 1ns/1ps
module odt_host_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Stall control from the bench
  input wire logic stall,
  // Read answers from the device
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  output logic rsp_ready,
  // Last answer taken and running count
  output logic [7:0] ans_data,
  output int unsigned ans_cnt
);
  // =====================================================================
  // Answer intake
  // Ready is the inverse of stall, so answers pile up in the device while stalled
  assign rsp_ready = ~stall;
  // Take an answer only at an edge where both sides agree
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ans_data <= 8'h00;
      ans_cnt <= 0;
    end else if (rsp_valid && rsp_ready) begin
      ans_data <= rsp_data;
      ans_cnt <= ans_cnt + 1;
    end
  end
endmodule : odt_host_model

// ===== dv/odt_debug_regs_test.sv
/*
  Self-checking bench for the debug register block: register table rows,
  force reset, arming, comparator breaks, event capture, profiling, stall.
  Assumes odt_pkg and the host model are compiled first; one 125 MHz clock.
*/
`timescale 1ns/1ps
module odt_debug_regs_test;
  typedef struct {
    logic [3:0] a;
    logic [7:0] d;
    logic bdc;
    logic [7:0] e;
  } odt_row_t;
  logic sys_clk, rst_b, bus_req, bus_wr, bus_bdc, bus_rdy, rsp_valid, rsp_ready;
  logic [3:0] bus_addr;
  logic [7:0] bus_wdata, rsp_data, cpu_data, ans_data, d, hi, lo;
  logic cpu_valid, cpu_rd, cpu_opfetch, cpu_cof, cpu_secure, mcu_reset_req, brk_req, brk_tag, stall;
  logic [15:0] cpu_addr;
  int unsigned ans_cnt, c0;
  int bad_count = 0;
  int n_compared = 0;
  // Write then read back; unmapped, trace and force-reset places read zero
  odt_row_t rows [9] = '{'{4'h0, 8'h12, 1'b0, 8'h12}, '{4'h1, 8'h34, 1'b0, 8'h34},
    '{4'h2, 8'h56, 1'b0, 8'h56}, '{4'h3, 8'h78, 1'b0, 8'h78}, '{4'h9, 8'h01, 1'b0, 8'h00},
    '{4'h4, 8'hAA, 1'b0, 8'h00}, '{4'h5, 8'hAA, 1'b0, 8'h00}, '{4'h6, 8'h0F, 1'b0, 8'h0F},
    '{4'hA, 8'hFF, 1'b0, 8'h00}};
  // =====================================================================
  // Design and host model
  odt_debug_regs odt_debug_regs_i (.sys_clk(sys_clk), .rst_b(rst_b), .bus_req(bus_req),
    .bus_wr(bus_wr), .bus_bdc(bus_bdc), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdy(bus_rdy), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ready(rsp_ready),
    .cpu_valid(cpu_valid), .cpu_rd(cpu_rd), .cpu_opfetch(cpu_opfetch), .cpu_cof(cpu_cof),
    .cpu_addr(cpu_addr), .cpu_data(cpu_data), .cpu_secure(cpu_secure),
    .mcu_reset_req(mcu_reset_req), .brk_req(brk_req), .brk_tag(brk_tag));
  odt_host_model odt_host_model_i (.sys_clk(sys_clk), .rst_b(rst_b), .stall(stall),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ready(rsp_ready),
    .ans_data(ans_data), .ans_cnt(ans_cnt));
  // =====================================================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Request held until the edge after bus_rdy is seen high; caller drops it
  task automatic issue(input logic wr, input logic bdc, input logic [3:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    bus_req = 1'b1;
    bus_wr = wr;
    bus_bdc = bdc;
    bus_addr = a;
    bus_wdata = wd;
    while (bus_rdy !== 1'b1 && n < 50) begin
      @(posedge sys_clk); #1;
      n++;
    end
    if (n == 50) bad_count++;
    @(posedge sys_clk); #1;
  endtask : issue
  task automatic wreg(input logic [3:0] a, input logic [7:0] wd, input logic bdc = 1'b0);
    issue(1'b1, bdc, a, wd);
    bus_req = 1'b0;
    bus_bdc = 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, output logic [7:0] rd);
    int n;
    int unsigned c;
    c = ans_cnt;
    n = 0;
    issue(1'b0, 1'b0, a, 8'h00);
    bus_req = 1'b0;
    while (ans_cnt == c && n < 20) begin
      @(posedge sys_clk); #1;
      n++;
    end
    if (n == 20) bad_count++;
    rd = (n == 20) ? 8'hXX : ans_data;
  endtask : rreg
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] rd;
    rreg(a, rd);
    chk(rd, e);
  endtask : rchk
  // One CPU bus cycle; left raised so captures can run back to back
  task automatic cpu(input logic [15:0] a, input logic rd, input logic [7:0] wd, input logic op);
    cpu_valid = 1'b1;
    cpu_rd = rd;
    cpu_addr = a;
    cpu_data = wd;
    cpu_opfetch = op;
    @(posedge sys_clk); #1;
  endtask : cpu
  // Arm with trg/ctl, make one access, then look for a break and the arm flag
  task automatic trig(input logic [7:0] trg, input logic [7:0] ctl, input logic [15:0] a,
    input logic rd, input logic eb, input logic et, input logic ea);
    logic got, tg;
    logic [7:0] s;
    got = 1'b0;
    tg = 1'b0;
    wreg(odt_pkg::OFS_TRG, trg);
    wreg(odt_pkg::OFS_CTL, ctl);
    cpu(a, rd, 8'h00, 1'b0);
    cpu_valid = 1'b0;
    repeat (4) begin
      if (brk_req === 1'b1) begin
        got = 1'b1;
        tg = brk_tag;
      end
      @(posedge sys_clk); #1;
    end
    chk(got, eb);
    if (eb) chk(tg, et);
    rreg(odt_pkg::OFS_STS, s);
    chk(s[odt_pkg::STS_RUN], ea);
    wreg(odt_pkg::OFS_CTL, 8'h00);
  endtask : trig
  task automatic report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // =====================================================================
  // Clock and watchdog; the tests need well under 5000 cycles
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #100us;
    bad_count++;
    report_and_stop();
  end
  // =====================================================================
  // Main sequence
  initial begin
    {bus_req, bus_wr, bus_bdc, bus_addr, bus_wdata, stall} = '0;
    {cpu_valid, cpu_rd, cpu_opfetch, cpu_cof, cpu_addr, cpu_data, cpu_secure} = '0;
    rst_b = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    foreach (rows[i]) begin
      wreg(rows[i].a, rows[i].d, rows[i].bdc);
      rchk(rows[i].a, rows[i].e);
    end
    // Force reset only from the background path, as a one-cycle pulse
    wreg(odt_pkg::OFS_FRC, 8'h01);
    chk(mcu_reset_req, 1'b0);
    wreg(odt_pkg::OFS_FRC, 8'h01, 1'b1);
    chk(mcu_reset_req, 1'b1);
    @(posedge sys_clk); #1;
    chk(mcu_reset_req, 1'b0);
    // Armed: comparators locked, control still open, enable low disarms
    wreg(odt_pkg::OFS_CTL, 8'hC0);
    wreg(odt_pkg::OFS_CA_HI, 8'hFF);
    rchk(odt_pkg::OFS_CA_HI, 8'h12);
    rchk(odt_pkg::OFS_CTL, 8'hC0);
    rreg(odt_pkg::OFS_STS, d);
    chk(d[odt_pkg::STS_RUN], 1'b1);
    wreg(odt_pkg::OFS_CTL, 8'h40);
    rreg(odt_pkg::OFS_STS, d);
    chk(d[odt_pkg::STS_RUN], 1'b0);
    // Secured part refuses the enable bit
    cpu_secure = 1'b1;
    wreg(odt_pkg::OFS_CTL, 8'h80);
    rchk(odt_pkg::OFS_CTL, 8'h00);
    cpu_secure = 1'b0;
    wreg(odt_pkg::OFS_CTL, 8'h80);
    rchk(odt_pkg::OFS_CTL, 8'h80);
    // Breaks: tag/force, direction qualifiers, break disabled, near miss
    trig(8'h00, 8'hF0, 16'h1234, 1'b1, 1'b1, 1'b1, 1'b0);
    trig(8'h00, 8'hD4, 16'h1234, 1'b1, 1'b0, 1'b0, 1'b1);
    trig(8'h00, 8'hD4, 16'h1234, 1'b0, 1'b1, 1'b0, 1'b0);
    trig(8'h01, 8'hD3, 16'h5678, 1'b0, 1'b0, 1'b0, 1'b1);
    trig(8'h01, 8'hD3, 16'h5678, 1'b1, 1'b1, 1'b0, 1'b0);
    trig(8'h00, 8'hC0, 16'h1234, 1'b1, 1'b0, 1'b0, 1'b0);
    trig(8'h00, 8'hF0, 16'h1235, 1'b1, 1'b0, 1'b0, 1'b1);
    trig(8'h05, 8'hD0, 16'h1234, 1'b1, 1'b0, 1'b0, 1'b1);
    trig(8'h06, 8'hD0, 16'h1234, 1'b1, 1'b1, 1'b0, 1'b0);
    trig(8'h07, 8'hD0, 16'h3000, 1'b0, 1'b1, 1'b0, 1'b0);
    // Begin trace from a comparator A hit; the eighth flow word ends it
    wreg(odt_pkg::OFS_TRG, 8'h40);
    wreg(odt_pkg::OFS_CTL, 8'hD0);
    cpu_cof = 1'b1;
    for (int i = 0; i < 8; i++) cpu(16'h1234 + 16'(i), 1'b1, 8'h00, 1'b0);
    {cpu_valid, cpu_cof} = 2'h0;
    chk(brk_req, 1'b1);
    // Event-only capture of eight bytes, with one read while armed
    wreg(odt_pkg::OFS_TRG, 8'h03);
    wreg(odt_pkg::OFS_CTL, 8'hC0);
    for (int i = 0; i < 8; i++) begin
      if (i == 3) begin
        cpu_valid = 1'b0;
        rreg(odt_pkg::OFS_FIFO_LO, d);
      end
      cpu(16'h5678, 1'b0, 8'(i + 1), 1'b0);
    end
    cpu_valid = 1'b0;
    @(posedge sys_clk); #1;
    rreg(odt_pkg::OFS_STS, d);
    chk(d & 8'h2F, 8'h08);
    rchk(odt_pkg::OFS_FIFO_HI, 8'h00);
    for (int i = 0; i < 8; i++) rchk(odt_pkg::OFS_FIFO_LO, 8'(i + 1));
    rreg(odt_pkg::OFS_STS, d);
    chk(d[3:0], 4'h8);
    // Profile: upper then lower each time; ninth read gives the first fetch
    wreg(odt_pkg::OFS_TRG, 8'h00);
    for (int i = 0; i < 10; i++) begin
      cpu(16'h1100 + 16'(i), 1'b1, 8'h00, 1'b1);
      cpu_valid = 1'b0;
      cpu_opfetch = 1'b0;
      rreg(odt_pkg::OFS_FIFO_HI, hi);
      rreg(odt_pkg::OFS_FIFO_LO, lo);
      if (i >= 8) chk({hi, lo}, 16'h1100 + 16'(i - 8));
    end
    // Two reads held back by a stalled host, then drained in order
    stall = 1'b1;
    c0 = ans_cnt;
    issue(1'b0, 1'b0, odt_pkg::OFS_CTL, 8'h00);
    issue(1'b0, 1'b0, odt_pkg::OFS_CA_HI, 8'h00);
    bus_req = 1'b0;
    @(posedge sys_clk); #1;
    chk(bus_rdy, 1'b0);
    stall = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(16'(ans_cnt - c0), 16'h0002);
    chk(ans_data, 8'h12);
    // Second reset while nothing is armed clears the comparators
    rst_b = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    for (int a = 0; a < 4; a++) rchk(4'(a), 8'h00);
    rchk(odt_pkg::OFS_FRC, 8'h00);
    report_and_stop();
  end
endmodule : odt_debug_regs_test
